// file: include/poe_regs_pkg.sv
// Constants for the port status and mode register bank of a four-port PoE source controller.
// Assumes a byte-wide command/data register port driven by an I2C front end on the same clock.
//
// Notes on behaviour
// - Port 3 and 4 status registers hold class in bits 7:4, detect in 3:0.
// - Port 1 and 2 status registers sit at 0x0c and 0x0d, same layout.
// - Class codes: unknown, classes 1-4, reserved as class 0, class 0, overcurrent, mismatch.
// - Mismatch from two-event class when results differ and second not overcurrent, or from a class code of 1000.
// - Overcurrent on first class event is recorded and no second event follows.
// - Auto mode does not power a port on an overcurrent or two-event mismatch result and returns it to idle.
// - Overcurrent or two-event mismatch classification sets that port's start-fault flag.
// - Detect codes: unknown, short, low, valid, high, open, transistor fault, legacy set.
// - Detect codes 1001 to 1100 appear only under legacy detection.
// - Power status holds power-good flags in 7:4 and power-on flags in 3:0.
// - Port turn-off, including fault turn-off, clears both of its power flags.
// - Power-good sets when on and drain below threshold, latched until turn-off or reset.
// - Address register shows the seven-bit bus address and the automatic bit at bit 7.
// - Automatic bit is sampled only after reset; it sets automatic-dependent reset values.
// - Mode register holds two bits per port, port 1 lowest: off, manual, semi, auto.
// - Off mode keeps a port dark and idle; manual mode never changes state alone.
// - Semi-auto automates detect and class; auto also automates power-on.
// - Detect-enable and classify-enable bits gate detection and classification per port.

package poe_regs_pkg;

    // ========================================================================
    // Command codes
    localparam logic [7:0] CMD_START_EVT_RO = 8'h08;
    localparam logic [7:0] CMD_START_EVT_COR = 8'h09;
    localparam logic [7:0] CMD_PORT1_RESULT = 8'h0c;
    localparam logic [7:0] CMD_PORT2_RESULT = 8'h0d;
    localparam logic [7:0] CMD_PORT3_RESULT = 8'h0e;
    localparam logic [7:0] CMD_PORT4_RESULT = 8'h0f;
    localparam logic [7:0] CMD_POWER_STATE  = 8'h10;
    localparam logic [7:0] CMD_BUS_ADDRESS  = 8'h11;
    localparam logic [7:0] CMD_MODE_SELECT  = 8'h12;
    localparam logic [7:0] CMD_DET_CLS_EN   = 8'h14;

    // ========================================================================
    // Field layout and reset values
    localparam int         NUM_PORTS        = 4;
    localparam int         CLASS_LSB        = 4;
    localparam int         PG_LSB           = 4;
    localparam int         AUTO_BIT         = 7;
    localparam logic [6:0] BUS_ADDR_INIT    = 7'h20;
    localparam logic       AUTO_INIT        = 1'b1;
    localparam logic [7:0] RESULT_RESET     = 8'h00;

    // ========================================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_OFF    = 2'h0,
        MODE_MANUAL = 2'h1,
        MODE_SEMI   = 2'h2,
        MODE_AUTO   = 2'h3
    } port_mode_type;

    // ========================================================================
    // Classification and detection codes
    localparam logic [3:0] CLS_UNKNOWN   = 4'h0;
    localparam logic [3:0] CLS_CLASS4    = 4'h4;
    localparam logic [3:0] CLS_RESERVED  = 4'h5;
    localparam logic [3:0] CLS_CLASS0    = 4'h6;
    localparam logic [3:0] CLS_OVERCUR   = 4'h7;
    localparam logic [3:0] CLS_MISMATCH  = 4'h8;
    localparam logic [3:0] DET_UNKNOWN   = 4'h0;
    localparam logic [3:0] DET_VALID     = 4'h4;
    localparam logic [3:0] DET_RSVD_A    = 4'h2;
    localparam logic [3:0] DET_RSVD_B    = 4'h7;
    localparam logic [3:0] DET_LEGACY_LO = 4'h9;
    localparam logic [3:0] DET_LEGACY_HI = 4'hc;
    localparam logic [3:0] DET_MAX       = 4'hc;

    // ========================================================================
    // Timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int MODE_SETTLE_US   = 1200;
    localparam int MODE_SETTLE_CYC  = (MODE_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: logic/poe_port_seq.sv
// Per-port detect, classify and power sequencer for one PoE port.
// Assumes analog measurement results arrive as same-clock strobes from the measurement engine.
`timescale 1ns/1ns

module poe_port_seq (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        nrst,
    // Configuration
    input  wire poe_regs_pkg::port_mode_type mode,
    input  wire logic                        detect_enable_bit,
    input  wire logic                        classify_enable_bit,
    input  wire logic                        legacy_enable,
    input  wire logic                        two_event_enable,
    input  wire logic                        power_on_cmd,
    input  wire logic                        power_off_cmd,
    // Measurement engine
    input  wire logic                        meas_done,
    input  wire logic [3:0]                  meas_code,
    input  wire logic                        pg_below,
    input  wire logic                        port_fault,
    output logic                             det_request,
    output logic                             cls_request,
    // Results
    output logic [3:0]                       port_class_result,
    output logic [3:0]                       port_detect_result,
    output logic                             power_on,
    output logic                             power_good,
    output logic                             start_fault_pulse
);
    import poe_regs_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_DETECT = 5'b00010,
        ST_CLS1   = 5'b00100,
        ST_CLS2   = 5'b01000,
        ST_ON     = 5'b10000
    } seq_state_type;

    typedef struct packed {
        seq_state_type state;
        logic [3:0]    cls;
        logic [3:0]    det;
        logic [3:0]    first_cls;
        logic          blocked;
        logic          pe;
        logic          pg;
        logic          strt;
    } seq_reg_type;

    seq_reg_type cur_ff;
    seq_reg_type nxt_ff;

    // Reserved class code reads as class 0.
    function automatic logic [3:0] map_class(input logic [3:0] code);
        if (code == CLS_RESERVED) begin
            return CLS_CLASS0;
        end
        if (code > CLS_MISMATCH) begin
            return CLS_UNKNOWN;
        end
        return code;
    endfunction

    // Legacy codes only under legacy detection; reserved codes fold to unknown.
    function automatic logic [3:0] map_detect(input logic [3:0] code, input logic legacy);
        if (code == DET_RSVD_A || code == DET_RSVD_B || code > DET_MAX) begin
            return DET_UNKNOWN;
        end
        if (!legacy && code >= DET_LEGACY_LO && code <= DET_LEGACY_HI) begin
            return DET_UNKNOWN;
        end
        return code;
    endfunction

    always_comb begin
        logic [3:0] cres;
        nxt_ff      = cur_ff;
        nxt_ff.strt = 1'b0;
        cres        = map_class(meas_code);
        unique case (cur_ff.state)
            ST_IDLE: begin
                // Off and manual modes never start a cycle on their own.
                if ((mode == MODE_SEMI || mode == MODE_AUTO) && detect_enable_bit) begin
                    nxt_ff.state = ST_DETECT;
                end
                if (power_on_cmd && mode != MODE_OFF) begin
                    nxt_ff.state = ST_ON;
                    nxt_ff.pe    = 1'b1;
                end
            end
            ST_DETECT: begin
                if (meas_done) begin
                    nxt_ff.det   = map_detect(meas_code, legacy_enable);
                    nxt_ff.state = (nxt_ff.det == DET_VALID && classify_enable_bit) ? ST_CLS1 : ST_IDLE;
                end
            end
            ST_CLS1: begin
                if (meas_done) begin
                    nxt_ff.first_cls = cres;
                    nxt_ff.cls       = cres;
                    nxt_ff.blocked   = 1'b0;
                    nxt_ff.state     = ST_IDLE;
                    if (cres == CLS_OVERCUR) begin
                        nxt_ff.strt    = 1'b1;
                        nxt_ff.blocked = 1'b1;
                    end else if (two_event_enable && cres != CLS_UNKNOWN) begin
                        nxt_ff.state = ST_CLS2;
                    end else if (mode == MODE_AUTO && cres != CLS_UNKNOWN) begin
                        nxt_ff.state = ST_ON;
                        nxt_ff.pe    = 1'b1;
                    end
                end
            end
            ST_CLS2: begin
                if (meas_done) begin
                    nxt_ff.state = ST_IDLE;
                    if (cres != CLS_OVERCUR && cres != cur_ff.first_cls) begin
                        nxt_ff.cls = CLS_MISMATCH;
                    end else begin
                        nxt_ff.cls = cres;
                    end
                    if (nxt_ff.cls == CLS_OVERCUR || nxt_ff.cls == CLS_MISMATCH) begin
                        nxt_ff.strt    = 1'b1;
                        nxt_ff.blocked = 1'b1;
                    end else if (mode == MODE_AUTO) begin
                        nxt_ff.state = ST_ON;
                        nxt_ff.pe    = 1'b1;
                    end
                end
            end
            ST_ON: begin
                if (pg_below) begin
                    nxt_ff.pg = 1'b1;
                end
            end
        endcase
        // Any turn-off, commanded, by fault or by off mode, drops both flags and results.
        if (power_off_cmd || port_fault || mode == MODE_OFF) begin
            nxt_ff.state = ST_IDLE;
            nxt_ff.pe    = 1'b0;
            nxt_ff.pg    = 1'b0;
            if (cur_ff.pe) begin
                nxt_ff.cls = CLS_UNKNOWN;
                nxt_ff.det = DET_UNKNOWN;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cur_ff <= '{state: ST_IDLE, cls: CLS_UNKNOWN, det: DET_UNKNOWN, first_cls: CLS_UNKNOWN,
                        blocked: 1'b0, pe: 1'b0, pg: 1'b0, strt: 1'b0};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign det_request        = (cur_ff.state == ST_DETECT);
    assign cls_request        = (cur_ff.state == ST_CLS1) || (cur_ff.state == ST_CLS2);
    assign port_class_result  = cur_ff.cls;
    assign port_detect_result = cur_ff.det;
    assign power_on           = cur_ff.pe;
    assign power_good         = cur_ff.pg;
    assign start_fault_pulse  = cur_ff.strt;

endmodule

// file: logic/poe_port_status_mode_regs.sv
// Register bank: port results, power status, bus address and operating mode for four ports.
// Assumes an I2C front end on ref_clk delivers decoded command, write and read strobes.
`timescale 1ns/1ns

module poe_port_status_mode_regs #(
    parameter int SETTLE_CYC = poe_regs_pkg::MODE_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                                   ref_clk,
    input  wire logic                                   nrst,
    // Register port from the I2C front end
    input  wire logic [7:0]                             cmd_code,
    input  wire logic                                   wr_strobe,
    input  wire logic [7:0]                             wr_data,
    input  wire logic                                   rd_strobe,
    output logic [7:0]                                  rd_data,
    // Nonvolatile configuration, from pins of the storage block
    input  wire logic [6:0]                             nv_bus_address,
    input  wire logic                                   nv_auto,
    // Per-port measurement engine
    input  wire logic [poe_regs_pkg::NUM_PORTS-1:0]     meas_done,
    input  wire logic [4*poe_regs_pkg::NUM_PORTS-1:0]   meas_code,
    input  wire logic [poe_regs_pkg::NUM_PORTS-1:0]     port_drain_pin,
    input  wire logic [poe_regs_pkg::NUM_PORTS-1:0]     port_fault,
    input  wire logic                                   legacy_enable,
    input  wire logic                                   two_event_enable,
    output logic [poe_regs_pkg::NUM_PORTS-1:0]          det_request,
    output logic [poe_regs_pkg::NUM_PORTS-1:0]          cls_request,
    // Power switches and flags
    output logic [poe_regs_pkg::NUM_PORTS-1:0]          port_power_on_flags,
    output logic [poe_regs_pkg::NUM_PORTS-1:0]          port_power_good_flags,
    output logic [poe_regs_pkg::NUM_PORTS-1:0]          start_fault_flag,
    output logic                                        mode_settle_busy
);
    import poe_regs_pkg::*;

    typedef struct packed {
        logic [1:0]             init_cnt;
        logic [6:0]             addr;
        logic                   auto_bit;
        logic [7:0]             mode;
        logic [7:0]             det_cls_en;
        logic [NUM_PORTS-1:0]   strt;
        logic [NUM_PORTS-1:0]   pwr_on_cmd;
        logic [NUM_PORTS-1:0]   pwr_off_cmd;
        logic [2*NUM_PORTS-1:0] drain_sync;
        logic [16:0]            settle;
        logic [7:0]             rd;
    } bank_reg_type;

    bank_reg_type cur_ff;
    bank_reg_type nxt_ff;

    logic [3:0]           cls_res [NUM_PORTS];
    logic [3:0]           det_res [NUM_PORTS];
    logic [NUM_PORTS-1:0] pe_w;
    logic [NUM_PORTS-1:0] pg_w;
    logic [NUM_PORTS-1:0] strt_pulse;
    logic [NUM_PORTS-1:0] drain_low;

    // ========================================================================
    // Port sequencers
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            poe_port_seq u_seq (
                .ref_clk             (ref_clk),
                .nrst                (nrst),
                .mode                (port_mode_type'(cur_ff.mode[2*p +: 2])),
                .detect_enable_bit   (cur_ff.det_cls_en[p]),
                .classify_enable_bit (cur_ff.det_cls_en[CLASS_LSB+p]),
                .legacy_enable       (legacy_enable),
                .two_event_enable    (two_event_enable),
                .power_on_cmd        (cur_ff.pwr_on_cmd[p]),
                .power_off_cmd       (cur_ff.pwr_off_cmd[p]),
                .meas_done           (meas_done[p]),
                .meas_code           (meas_code[4*p +: 4]),
                .pg_below            (drain_low[p]),
                .port_fault          (port_fault[p]),
                .det_request         (det_request[p]),
                .cls_request         (cls_request[p]),
                .port_class_result   (cls_res[p]),
                .port_detect_result  (det_res[p]),
                .power_on            (pe_w[p]),
                .power_good          (pg_w[p]),
                .start_fault_pulse   (strt_pulse[p])
            );
            // Drain comparator is an asynchronous pin, so only the second stage is read.
            assign drain_low[p] = cur_ff.drain_sync[NUM_PORTS+p];
        end
    endgenerate

    function automatic logic [7:0] result_byte(input logic [3:0] cls, input logic [3:0] det);
        return {cls, det};
    endfunction

    function automatic logic off_to_active(input logic [1:0] old_m, input logic [1:0] new_m);
        return (old_m == MODE_OFF) && (new_m == MODE_SEMI || new_m == MODE_AUTO);
    endfunction

    // ========================================================================
    // Register behaviour
    always_comb begin
        logic [7:0] rsel;
        logic       wr_ok;
        nxt_ff             = cur_ff;
        nxt_ff.pwr_on_cmd  = '0;
        nxt_ff.pwr_off_cmd = '0;
        rsel               = 8'h00;
        wr_ok              = 1'b1;
        nxt_ff.drain_sync  = {cur_ff.drain_sync[NUM_PORTS-1:0], port_drain_pin};

        // The nonvolatile bits are captured after reset release, never during it.
        if (cur_ff.init_cnt != 2'h0) begin
            nxt_ff.init_cnt = cur_ff.init_cnt - 2'h1;
            nxt_ff.addr     = nv_bus_address;
            nxt_ff.auto_bit = nv_auto;
            nxt_ff.mode       = nv_auto ? {NUM_PORTS{MODE_AUTO}} : 8'h00;
            nxt_ff.det_cls_en = nv_auto ? 8'hff : 8'h00;
            wr_ok             = 1'b0;
        end

        if (cur_ff.settle != 17'h00000) begin
            nxt_ff.settle = cur_ff.settle - 17'h00001;
        end

        // Only mode and enable registers accept writes; read-only codes drop silently.
        if (wr_strobe && wr_ok) begin
            unique case (cmd_code)
                CMD_MODE_SELECT: begin
                    nxt_ff.mode = wr_data;
                    for (int i = 0; i < NUM_PORTS; i++) begin
                        if (off_to_active(cur_ff.mode[2*i +: 2], wr_data[2*i +: 2])) begin
                            nxt_ff.settle = 17'(SETTLE_CYC);
                        end
                    end
                end
                CMD_DET_CLS_EN: begin
                    nxt_ff.det_cls_en = wr_data;
                end
                default: begin
                end
            endcase
        end

        // Start-fault flags: hardware set wins over a clear-on-read in the same cycle.
        if (rd_strobe && cmd_code == CMD_START_EVT_COR) begin
            nxt_ff.strt = '0;
        end
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (strt_pulse[i]) begin
                nxt_ff.strt[i] = 1'b1;
            end
        end

        unique case (cmd_code)
            CMD_PORT1_RESULT: rsel = result_byte(cls_res[0], det_res[0]);
            CMD_PORT2_RESULT: rsel = result_byte(cls_res[1], det_res[1]);
            CMD_PORT3_RESULT: rsel = result_byte(cls_res[2], det_res[2]);
            CMD_PORT4_RESULT: rsel = result_byte(cls_res[3], det_res[3]);
            CMD_POWER_STATE:  rsel = {pg_w, pe_w};
            CMD_BUS_ADDRESS:  rsel = {cur_ff.auto_bit, cur_ff.addr};
            CMD_MODE_SELECT:  rsel = cur_ff.mode;
            CMD_DET_CLS_EN:   rsel = cur_ff.det_cls_en;
            CMD_START_EVT_RO,
            CMD_START_EVT_COR: rsel = {4'h0, cur_ff.strt};
            default:          rsel = 8'h00;
        endcase
        if (rd_strobe) begin
            nxt_ff.rd = rsel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cur_ff <= '{init_cnt: 2'h1, addr: BUS_ADDR_INIT, auto_bit: AUTO_INIT, mode: 8'h00,
                        det_cls_en: 8'h00, strt: '0, pwr_on_cmd: '0, pwr_off_cmd: '0,
                        drain_sync: '0, settle: 17'h00000, rd: RESULT_RESET};
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign rd_data               = cur_ff.rd;
    assign port_power_on_flags   = pe_w;
    assign port_power_good_flags = pg_w;
    assign start_fault_flag      = cur_ff.strt;
    assign mode_settle_busy      = (cur_ff.settle != 17'h00000);

endmodule

// file: testbench/poe_port_status_mode_regs_sva.sv
// Checker for the port register bank: read answers, power flags and the mode settle window.
// Assumes it is bound to the register bank and sees only that module's ports.
`timescale 1ns/1ns
module poe_regs_sva #(
    parameter int SETTLE_CYC = 20
) (
    input wire logic       ref_clk, nrst, wr_strobe, rd_strobe, mode_settle_busy, nv_auto,
    input wire logic [7:0] cmd_code, rd_data, wr_data,
    input wire logic [6:0] nv_bus_address,
    input wire logic [3:0] port_power_on_flags, port_power_good_flags, start_fault_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ========================================================================
    // Helper logic
    int         busy_cnt_ff;
    logic [7:0] mode_sh_ff;
    logic       init_ff, reload;
    // A mode write restarts the window only when some port goes from off mode to semi-auto or auto mode.
    always_comb begin
        reload = 1'b0;
        for (int i = 0; i < 4; i++) reload |= mode_sh_ff[2*i+:2] == 2'h0 && wr_data[2*i+1];
        reload &= wr_strobe && cmd_code == 8'h12 && !init_ff;
    end
    always_ff @(posedge ref_clk) begin
        init_ff <= !nrst;
        if (init_ff) mode_sh_ff <= nv_auto ? 8'hff : 8'h00;
        else if (wr_strobe && cmd_code == 8'h12) mode_sh_ff <= wr_data;
        busy_cnt_ff <= (!nrst || reload || !mode_settle_busy) ? 0 : busy_cnt_ff + 1;
    end
    sequence s_rd(logic [7:0] c);
        rd_strobe && cmd_code == c;
    endsequence
    sequence s_mode_wr;
        wr_strobe && cmd_code == 8'h12;
    endsequence
    // ========================================================================
    // Assertions
    a_reset_clear: assert property (disable iff (1'b0) !nrst |=> rd_data == 8'h00 && port_power_on_flags == 4'h0)
        else $error("outputs not cleared by reset");
    a_read_holds: assert property (!rd_strobe |=> $stable(rd_data))
        else $error("read data changed without a read");
    a_good_needs_on: assert property ((port_power_good_flags & ~port_power_on_flags) == 4'h0)
        else $error("power good set on a port that is off");
    a_address_read: assert property (s_rd(8'h11) |=> rd_data[6:0] == $past(nv_bus_address))
        else $error("bus address read wrong");
    a_unmapped_zero: assert property (s_rd(8'h30) |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_status_read: assert property (s_rd(8'h10) |=> rd_data == {$past(port_power_good_flags), $past(port_power_on_flags)})
        else $error("power status read wrong");
    a_fault_read: assert property (s_rd(8'h08) |=> rd_data[3:0] == $past(start_fault_flag))
        else $error("start fault read wrong");
    a_settle_cause: assert property ($rose(mode_settle_busy) |-> $past(wr_strobe) && $past(cmd_code) == 8'h12)
        else $error("settle window without a mode write");
    a_settle_length: assert property ($fell(mode_settle_busy) |-> busy_cnt_ff == SETTLE_CYC)
        else $error("settle window has wrong length");
    c_mode_write: cover property (s_mode_wr ##[1:3] $rose(mode_settle_busy));
endmodule
bind poe_port_status_mode_regs poe_regs_sva #(.SETTLE_CYC(SETTLE_CYC)) i_poe_regs_sva (.*);

// file: testbench/poe_meas_model.sv
// Measurement engine model: answers detect and classify requests with codes set by the bench.
// Assumes requests are levels that drop once the sequencer has taken the answer.
`timescale 1ns/1ns
module poe_meas_model (
    input  wire logic        ref_clk,
    input  wire logic [3:0]  det_request, cls_request,
    input  wire logic [15:0] det_codes, cls_codes,
    output logic [3:0]       meas_done,
    output logic [15:0]      meas_code
);
    logic [3:0] wait_ff [4];
    // Later ports answer more slowly, so prompt and slow replies are both seen.
    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < 4; p++) begin
            meas_done[p] <= 1'b0;
            // Outside the pulse the code wanders, so a stale sample never looks valid.
            meas_code[4*p+:4] <= wait_ff[p] ^ 4'ha;
            if (!(det_request[p] || cls_request[p])) begin
                wait_ff[p] <= 4'h0;
            end else if (wait_ff[p] == 4'(3 + 2*p)) begin
                meas_done[p] <= 1'b1;
                wait_ff[p] <= 4'h0;
                meas_code[4*p+:4] <= det_request[p] ? det_codes[4*p+:4] : cls_codes[4*p+:4];
            end else begin
                wait_ff[p] <= wait_ff[p] + 4'h1;
            end
        end
    end
endmodule

// file: testbench/poe_port_status_mode_regs_tb_top.sv
// Self-checking bench for the port register bank with the measurement model on its far side.
// Assumes a 100 MHz clock and the short settle window set at the instance.
`timescale 1ns/1ns
module poe_port_status_mode_regs_tb_top;
    logic        ref_clk, nrst, wr_strobe, rd_strobe, nv_auto, legacy_enable, two_event_enable, mode_settle_busy;
    logic [7:0]  cmd_code, wr_data, rd_data, d;
    logic [6:0]  nv_bus_address;
    logic [3:0]  meas_done, port_drain_pin, port_fault, det_request, cls_request;
    logic [3:0]  port_power_on_flags, port_power_good_flags, start_fault_flag;
    logic [15:0] meas_code, det_codes, cls_codes;
    logic [7:0]  exp_q[$];
    string       nm_q[$];
    logic        rd_pend;
    int          failures, n_tests, i;
    integer      seed = 40364;
    poe_port_status_mode_regs #(.SETTLE_CYC(20)) i_poe_port_status_mode_regs (.*);
    poe_meas_model i_poe_meas_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ========================================================================
    // Tasks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        @(negedge ref_clk);
        cmd_code = c;
        rd_strobe = 1'b1;
        exp_q.push_back(e);
        nm_q.push_back($sformatf("read_%h", c));
        @(negedge ref_clk);
        rd_strobe = 1'b0;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] v);
        @(negedge ref_clk);
        cmd_code = c;
        wr_data = v;
        wr_strobe = 1'b1;
        @(negedge ref_clk);
        wr_strobe = 1'b0;
    endtask
    task automatic do_reset(input logic a);
        @(negedge ref_clk);
        nv_auto = a;
        nrst = 1'b0;
        repeat (20) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Read answers are compared one cycle after the strobe was taken.
    always @(posedge ref_clk) begin
        rd_pend <= rd_strobe & nrst;
        if (rd_pend === 1'b1) chk(nm_q.pop_front(), rd_data, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        print_verdict();
    end
    // ========================================================================
    // Main sequence
    initial begin
        {nrst, wr_strobe, rd_strobe, cmd_code, wr_data, port_fault, port_drain_pin} = '0;
        {legacy_enable, two_event_enable, nv_auto} = '0;
        nv_bus_address = 7'h20;
        det_codes = 16'h4444;
        cls_codes = 16'h6453;
        do_reset(1'b0);
        for (i = 12; i < 19; i++) rd(8'(i), (i == 17) ? 8'h20 : 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        repeat (4) begin
            d = 8'($random(seed));
            wr(8'h12, d);
            rd(8'h12, d);
        end
        wr(8'h12, 8'h00);
        wr(8'h12, 8'hff);
        @(negedge ref_clk);
        chk("settle_busy", {7'h0, mode_settle_busy}, 8'h01);
        $display("register test done");
        for (i = 0; i < 200 && mode_settle_busy !== 1'b0; i++) @(negedge ref_clk);
        chk("settle_len", 8'(i), 8'h13);
        wr(8'h14, 8'hff);
        for (i = 0; i < 3000 && port_power_on_flags !== 4'hf; i++) @(negedge ref_clk);
        port_drain_pin = 4'hf;
        repeat (6) @(negedge ref_clk);
        rd(8'h10, 8'hff);
        rd(8'h0c, 8'h34);
        rd(8'h0d, 8'h64);
        rd(8'h0e, 8'h44);
        rd(8'h0f, 8'h64);
        cls_codes[15:12] = 4'h7;
        port_fault[3] = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd(8'h10, 8'h77);
        port_fault[3] = 1'b0;
        for (i = 0; i < 3000 && start_fault_flag[3] !== 1'b1; i++) @(negedge ref_clk);
        wr(8'h12, 8'h7f);
        rd(8'h0f, 8'h74);
        rd(8'h08, 8'h08);
        rd(8'h09, 8'h08);
        rd(8'h08, 8'h00);
        chk("port4_on", {7'h0, port_power_on_flags[3]}, 8'h00);
        $display("fault test done");
        wr(8'h12, 8'h00);
        repeat (4) @(negedge ref_clk);
        rd(8'h10, 8'h00);
        rd(8'h0c, 8'h00);
        chk("off_requests", {4'h0, det_request | cls_request}, 8'h00);
        two_event_enable = 1'b1;
        det_codes[11:8] = 4'h9;
        do_reset(1'b1);
        rd(8'h11, 8'ha0);
        rd(8'h12, 8'hff);
        nv_auto = 1'b0;
        rd(8'h11, 8'ha0);
        for (i = 0; i < 3000 && port_power_on_flags !== 4'h3; i++) @(negedge ref_clk);
        repeat (30) @(negedge ref_clk);
        rd(8'h10, 8'h33);
        rd(8'h0e, 8'h00);
        rd(8'h0f, 8'h74);
        wr(8'h14, 8'hfb);
        repeat (12) @(negedge ref_clk);
        chk("port3_idle", {7'h0, det_request[2]}, 8'h00);
        repeat (4) @(negedge ref_clk);
        $display("reset test done");
        print_verdict();
    end
endmodule
